// file: edl_ctrl.v
// Edge event line controller with an AHB-Lite register slave.
//
// The address map and the AHB-Lite register port were decided locally.
`timescale 1ns/1ns
`include "edl_map.vh"

module edl_ctrl (
   input wire mclk,
   input wire sys_rst,
   input wire [`EDL_PINS-1:0] gpio_pins,
   input wire [`EDL_INT_LINES-1:0] int_evt,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg hreadyout,
   output reg hresp,
   output reg [31:0] hrdata,
   output reg [`EDL_LINES-1:0] irq_req,
   output reg [`EDL_LINES-1:0] evt_pulse
);

   // ==========================================================================
   // Registers
   // ==========================================================================
   reg [`EDL_LINES-1:0] int_mask;
   reg [`EDL_LINES-1:0] evt_mask;
   reg [`EDL_LINES-1:0] rise_sel;
   reg [`EDL_LINES-1:0] fall_sel;
   reg [`EDL_LINES-1:0] pending;
   reg [`EDL_EXT_LINES*`EDL_SEL_W-1:0] pin_sel;
   reg wr_pend;
   reg rd_pend;
   reg [7:0] ph_addr;
   wire [`EDL_LINES-1:0] edge_hit;
   wire [`EDL_LINES-1:0] clr_mask;
   wire addr_ok;
   reg [31:0] next_rdata;

   assign addr_ok = hsel & htrans[1] & hready;

   // ==========================================================================
   // External lines: pin select, pin-clocked edge capture, synchroniser
   // ==========================================================================
   genvar g;
   generate
      for (g = 0; g < `EDL_EXT_LINES; g = g + 1) begin : ext_line
         wire [`EDL_SEL_W-1:0] sel;
         wire pin;
         reg rise_tog;
         reg fall_tog;
         reg r_s1, r_s2, r_s3;
         reg f_s1, f_s2, f_s3;
         // Changing a select while the old and new pins differ in level looks like an edge.
         // Software should mask the line while it moves the select.
         assign sel = pin_sel[g*`EDL_SEL_W +: `EDL_SEL_W];
         // Out-of-range selections feed a steady low level.
         assign pin = (sel < `EDL_PINS) ? gpio_pins[sel] : 1'b0;
         // The pin itself clocks the toggles, so a pulse shorter than mclk still flips them.
         // Each toggle then crosses into mclk through two flip-flops; a third stage
         // holds the previous synchronised level so that a change marks one edge.
         // Two edges of one kind within one mclk period flip the toggle back and mark no edge.
         always @(posedge pin or posedge sys_rst) begin
            if (sys_rst) begin
               rise_tog <= 1'b0;
            end else begin
               rise_tog <= ~rise_tog;
            end
         end
         always @(negedge pin or posedge sys_rst) begin
            if (sys_rst) begin
               fall_tog <= 1'b0;
            end else begin
               fall_tog <= ~fall_tog;
            end
         end
         always @(posedge mclk) begin
            if (sys_rst) begin
               r_s1 <= 1'b0;
               r_s2 <= 1'b0;
               r_s3 <= 1'b0;
               f_s1 <= 1'b0;
               f_s2 <= 1'b0;
               f_s3 <= 1'b0;
            end else begin
               r_s1 <= rise_tog;
               r_s2 <= r_s1;
               r_s3 <= r_s2;
               f_s1 <= fall_tog;
               f_s2 <= f_s1;
               f_s3 <= f_s2;
            end
         end
         assign edge_hit[g] = ((r_s2 ^ r_s3) & rise_sel[g]) |
                              ((f_s2 ^ f_s3) & fall_sel[g]);
      end

      // ==========================================================================
      // Internal lines: same-clock sources, sampled edge detection
      // ==========================================================================
      for (g = 0; g < `EDL_INT_LINES; g = g + 1) begin : int_line
         reg prev;
         always @(posedge mclk) begin
            if (sys_rst) begin
               prev <= 1'b0;
            end else begin
               prev <= int_evt[g];
            end
         end
         assign edge_hit[`EDL_EXT_LINES+g] =
            (int_evt[g] & ~prev & rise_sel[`EDL_EXT_LINES+g]) |
            (~int_evt[g] & prev & fall_sel[`EDL_EXT_LINES+g]);
      end
   endgenerate

   // ==========================================================================
   // Pending, interrupt and event outputs
   // ==========================================================================
   wire [`EDL_LINES-1:0] next_pending;

   // Writing one to a pending bit clears it; writing zero leaves it alone.
   assign clr_mask = (wr_pend && ph_addr == `EDL_OFS_PENDING) ?
                     hwdata[`EDL_LINES-1:0] : {`EDL_LINES{1'b0}};

   // A new edge in the cycle of a clear keeps the bit set.
   assign next_pending = (pending & ~clr_mask) | (edge_hit & int_mask);

   always @(posedge mclk) begin
      if (sys_rst) begin
         pending <= {`EDL_LINES{1'b0}};
      end else begin
         pending <= next_pending;
      end
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         irq_req <= {`EDL_LINES{1'b0}};
      end else begin
         irq_req <= next_pending & int_mask;
      end
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         evt_pulse <= {`EDL_LINES{1'b0}};
      end else begin
         evt_pulse <= edge_hit & evt_mask;
      end
   end

   // ==========================================================================
   // AHB-Lite slave: writes take no wait, reads take one wait state
   // ==========================================================================
   always @* begin
      next_rdata = 32'h00000000;
      case (ph_addr)
         `EDL_OFS_INT_MASK: next_rdata[`EDL_LINES-1:0] = int_mask;
         `EDL_OFS_EVT_MASK: next_rdata[`EDL_LINES-1:0] = evt_mask;
         `EDL_OFS_RISE_SEL: next_rdata[`EDL_LINES-1:0] = rise_sel;
         `EDL_OFS_FALL_SEL: next_rdata[`EDL_LINES-1:0] = fall_sel;
         `EDL_OFS_PENDING: next_rdata[`EDL_LINES-1:0] = pending;
         `EDL_OFS_PIN_SEL0: next_rdata = pin_sel[31:0];
         `EDL_OFS_PIN_SEL1: next_rdata = pin_sel[63:32];
         `EDL_OFS_PIN_SEL2: next_rdata = pin_sel[95:64];
         `EDL_OFS_PIN_SEL3: next_rdata = pin_sel[127:96];
         default: next_rdata = 32'h00000000;
      endcase
   end

   // Address phase capture: the request is taken only while the bus is ready.
   always @(posedge mclk) begin
      if (sys_rst) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         ph_addr <= 8'h00;
      end else begin
         wr_pend <= addr_ok & hwrite;
         rd_pend <= addr_ok & ~hwrite;
         if (addr_ok) begin
            ph_addr <= {haddr[7:2], 2'b00};
         end
      end
   end

   // Every transfer ends OKAY; the slave has no error cases.
   always @(posedge mclk) begin
      if (sys_rst) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   // A read holds the bus for one cycle so that the read data leave a flip-flop.
   always @(posedge mclk) begin
      if (sys_rst) begin
         hreadyout <= 1'b1;
         hrdata <= 32'h00000000;
      end else begin
         if (addr_ok & ~hwrite) begin
            hreadyout <= 1'b0;
         end else if (rd_pend) begin
            hrdata <= next_rdata;
            hreadyout <= 1'b1;
         end else begin
            hreadyout <= 1'b1;
         end
      end
   end

   // ==========================================================================
   // Register write decode
   // ==========================================================================
   // A write lands at the edge that closes its data phase, while hwdata stands.
   wire wr_int_mask;
   wire wr_evt_mask;
   wire wr_rise_sel;
   wire wr_fall_sel;
   wire wr_pin_sel0;
   wire wr_pin_sel1;
   wire wr_pin_sel2;
   wire wr_pin_sel3;

   assign wr_int_mask = wr_pend & (ph_addr == `EDL_OFS_INT_MASK);
   assign wr_evt_mask = wr_pend & (ph_addr == `EDL_OFS_EVT_MASK);
   assign wr_rise_sel = wr_pend & (ph_addr == `EDL_OFS_RISE_SEL);
   assign wr_fall_sel = wr_pend & (ph_addr == `EDL_OFS_FALL_SEL);
   assign wr_pin_sel0 = wr_pend & (ph_addr == `EDL_OFS_PIN_SEL0);
   assign wr_pin_sel1 = wr_pend & (ph_addr == `EDL_OFS_PIN_SEL1);
   assign wr_pin_sel2 = wr_pend & (ph_addr == `EDL_OFS_PIN_SEL2);
   assign wr_pin_sel3 = wr_pend & (ph_addr == `EDL_OFS_PIN_SEL3);

   // ==========================================================================
   // Configuration registers
   // ==========================================================================
   always @(posedge mclk) begin
      if (sys_rst) begin
         int_mask <= `EDL_RST_INT_MASK;
      end else if (wr_int_mask) begin
         int_mask <= hwdata[`EDL_LINES-1:0];
      end
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         evt_mask <= `EDL_RST_EVT_MASK;
      end else if (wr_evt_mask) begin
         evt_mask <= hwdata[`EDL_LINES-1:0];
      end
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         rise_sel <= `EDL_RST_RISE_SEL;
      end else if (wr_rise_sel) begin
         rise_sel <= hwdata[`EDL_LINES-1:0];
      end
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         fall_sel <= `EDL_RST_FALL_SEL;
      end else if (wr_fall_sel) begin
         fall_sel <= hwdata[`EDL_LINES-1:0];
      end
   end

   // Four select words, one byte per external line, four lines per word.
   always @(posedge mclk) begin
      if (sys_rst) begin
         pin_sel[31:0] <= `EDL_RST_PIN_SEL_WORD;
      end else if (wr_pin_sel0) begin
         pin_sel[31:0] <= hwdata;
      end
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         pin_sel[63:32] <= `EDL_RST_PIN_SEL_WORD;
      end else if (wr_pin_sel1) begin
         pin_sel[63:32] <= hwdata;
      end
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         pin_sel[95:64] <= `EDL_RST_PIN_SEL_WORD;
      end else if (wr_pin_sel2) begin
         pin_sel[95:64] <= hwdata;
      end
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         pin_sel[127:96] <= `EDL_RST_PIN_SEL_WORD;
      end else if (wr_pin_sel3) begin
         pin_sel[127:96] <= hwdata;
      end
   end

endmodule // edl_ctrl

// file: edl_map.vh
// Register offsets, field positions and reset values of the edge event line controller.
`ifndef EDL_MAP_VH
`define EDL_MAP_VH

// ==========================================================================
// Geometry
// ==========================================================================
`define EDL_LINES 23
`define EDL_EXT_LINES 16
`define EDL_INT_LINES 7
`define EDL_PINS 140
`define EDL_SEL_W 8

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define EDL_OFS_INT_MASK 8'h00
`define EDL_OFS_EVT_MASK 8'h04
`define EDL_OFS_RISE_SEL 8'h08
`define EDL_OFS_FALL_SEL 8'h0C
`define EDL_OFS_PENDING 8'h10
`define EDL_OFS_PIN_SEL0 8'h20
`define EDL_OFS_PIN_SEL1 8'h24
`define EDL_OFS_PIN_SEL2 8'h28
`define EDL_OFS_PIN_SEL3 8'h2C

// ==========================================================================
// Reset values
// ==========================================================================
`define EDL_RST_INT_MASK 23'h000000
`define EDL_RST_EVT_MASK 23'h000000
`define EDL_RST_RISE_SEL 23'h000000
`define EDL_RST_FALL_SEL 23'h000000
`define EDL_RST_PIN_SEL 128'h0
`define EDL_RST_PIN_SEL_WORD 32'h00000000

`endif

// file: edl_ctrl_monitor.sv
// Port assertions for the edge event line controller.
`timescale 1ns/1ns
`include "edl_map.vh"
module edl_ctrl_monitor (
   input wire mclk,
   input wire sys_rst,
   input wire [`EDL_INT_LINES-1:0] int_evt,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   input wire hreadyout,
   input wire hresp,
   input wire [31:0] hrdata,
   input wire [`EDL_LINES-1:0] irq_req,
   input wire [`EDL_LINES-1:0] evt_pulse
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // Cycles since a write that may lower a request.
   logic [2:0] since_clr;
   wire take = hsel && htrans[1] && hready;
   wire clr_wr = take && hwrite && (haddr[7:0] == 8'h00 || haddr[7:0] == 8'h10);
   always @(posedge mclk) begin
      if (sys_rst || clr_wr)
         since_clr <= 3'h0;
      else if (since_clr != 3'h7)
         since_clr <= since_clr + 3'h1;
   end
   chk_resp_okay: assert property (!hresp)
      else $error("hresp not okay");
   chk_reset_idle: assert property (disable iff (1'b0) sys_rst |=>
      irq_req == 0 && evt_pulse == 0 && hreadyout) else $error("reset state");
   chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait");
   chk_write_nowait: assert property (take && hwrite |=> hreadyout)
      else $error("write wait");
   chk_rdata_holds: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
      else $error("hrdata moved");
   chk_irq_sticky: assert property ((|($past(irq_req) & ~irq_req)) |-> since_clr <= 3)
      else $error("irq dropped");
   chk_evt_cause: assert property ((evt_pulse[22:16] & ~(($past(int_evt) ^
      $past(int_evt, 2)) | ($past(int_evt, 2) ^ $past(int_evt, 3)))) == 0)
      else $error("event without edge");
endmodule // edl_ctrl_monitor
bind edl_ctrl edl_ctrl_monitor i_edl_ctrl_monitor (.mclk, .sys_rst, .int_evt, .hsel,
   .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .irq_req, .evt_pulse);

// file: edl_src_model.sv
// Pin source model driving the selectable input pins.
`timescale 1ns/1ns
`include "edl_map.vh"
module edl_src_model (
   output logic [`EDL_PINS-1:0] gpio_pins
);
   initial gpio_pins = '0;
   // Toggles a pin; a positive width toggles back after that many ns.
   task automatic pin_flip(input int p, input int w);
      #5;
      gpio_pins[p] = ~gpio_pins[p];
      if (w > 0) begin
         #w gpio_pins[p] = ~gpio_pins[p];
      end
   endtask
endmodule // edl_src_model

// file: edl_ctrl_tb.sv
// Self-checking bench for the edge event line controller.
`timescale 1ns/1ns
`include "edl_map.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end
module edl_ctrl_tb;
   logic mclk, sys_rst, hsel, hwrite;
   logic [`EDL_INT_LINES-1:0] int_evt;
   logic [31:0] haddr, hwdata, q;
   logic [1:0] htrans;
   logic [2:0] hsize;
   wire [`EDL_PINS-1:0] gpio_pins;
   wire hreadyout, hresp;
   wire [31:0] hrdata;
   wire [`EDL_LINES-1:0] irq_req, evt_pulse;
   int n_errors = 0, checked = 0, cycles = 0, n_evt = 0;
   edl_ctrl i_edl_ctrl (.mclk, .sys_rst, .gpio_pins, .int_evt, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq_req,
      .evt_pulse);
   edl_src_model i_edl_src_model (.gpio_pins);
   initial begin
      mclk = 0;
      forever #25 mclk = ~mclk;
   end
   task give_verdict();
      $display("checked=%0d n_errors=%0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [31:0] a, d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [31:0] a, e, input string n);
      bus(1'b0, a, 32'h0);
      `CHK(n, e, q)
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (evt_pulse[16] === 1'b1) n_evt++;
      if (cycles == 5000) begin
         n_errors++;
         give_verdict();
      end
   end
   initial begin
      sys_rst = 1; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2;
      hwdata = 0; int_evt = 0;
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      for (int a = 0; a < 'h30; a += 4) rd(a, 32'h0, "reset value");
      wr(`EDL_OFS_INT_MASK, 32'h8001);
      wr(`EDL_OFS_EVT_MASK, 32'h10000);
      wr(`EDL_OFS_RISE_SEL, 32'h10003);
      wr(`EDL_OFS_FALL_SEL, 32'h18000);
      wr(`EDL_OFS_PIN_SEL0, 32'h0605);
      wr(`EDL_OFS_PIN_SEL3, 32'h8B000000);
      wr(8'h14, 32'hFFFFFFFF);
      rd(8'h14, 32'h0, "unmapped");
      rd(`EDL_OFS_PIN_SEL3, 32'h8B000000, "pin_sel3");
      i_edl_src_model.pin_flip(139, 0);
      repeat (6) @(posedge mclk);
      rd(`EDL_OFS_PENDING, 32'h0, "pend none");
      i_edl_src_model.pin_flip(5, 10);
      i_edl_src_model.pin_flip(6, 10);
      repeat (6) @(posedge mclk);
      rd(`EDL_OFS_PENDING, 32'h1, "pend short");
      `CHK("irq", 23'h1, irq_req)
      i_edl_src_model.pin_flip(139, 0);
      repeat (6) @(posedge mclk);
      rd(`EDL_OFS_PENDING, 32'h8001, "pend fall");
      wr(`EDL_OFS_PENDING, 32'h1);
      rd(`EDL_OFS_PENDING, 32'h8000, "pend clr");
      `CHK("irq clr", 23'h8000, irq_req)
      int_evt[0] <= 1'b1;
      repeat (4) @(posedge mclk);
      int_evt[0] <= 1'b0;
      repeat (4) @(posedge mclk);
      `CHK("evt count", n_evt, 2)
      rd(`EDL_OFS_PENDING, 32'h8000, "pend evt");
      give_verdict();
   end
endmodule // edl_ctrl_tb
